// >>> dct_top.sv
/*
  Dual compare timer with half-second tick unit and register port.
  Assumes a single-cycle strobe master on the same clock.
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "dct_map.svh"

// Operation
// RULE1: Timer A match with gate sets flag, irq
// RULE2: Timer B match with gate sets flag, irq
// RULE3: Timer interrupt holds until flag cleared
// RULE4: Flag bit 0; one clears, zero keeps
// RULE5: Timer A count readable and loadable
// RULE6: Timer B count readable and loadable
// RULE7: Tick flag bit 0, gate bit 1, W1C
// RULE8: Software disables unit before changing settings
// RULE9: Enabled count steps per timer clock; else holds
module dct_top
  import dct_pkg::*;
#(
  parameter int TICK_CYCLES = `DCT_TICK_PERIOD_MS * `DCT_CLOCK_KHZ,
  parameter int TIMER_DIV   = `DCT_TIMER_DIV
) (
  input  wire logic                   clock,        // 250 MHz clock
  input  wire logic                   rst_n,        // Asynchronous reset, low
  input  wire logic [`DCT_ADDR_W-1:0] reg_addr,     // Byte address
  input  wire logic [31:0]            reg_wdata,    // Write data
  input  wire logic                   reg_we,       // Write strobe
  input  wire logic                   reg_re,       // Read strobe
  output logic      [31:0]            reg_rdata,    // Read data, next cycle
  output logic                        timer_a_irq,  // Timer A interrupt
  output logic                        timer_b_irq,  // Timer B interrupt
  output logic                        tick_b_irq,   // Tick unit interrupt
  output logic                        irq           // Combined interrupt
);
  dct_unit_if #(.W(32)) a_if ();
  dct_unit_if #(.W(32)) b_if ();
  dct_unit_if #(.W(32)) t_if ();

  // Address decode
  dct_sel_type sel;
  always_comb begin
    unique case (reg_addr)
      `DCT_TIMER_A_CONTROL: sel = DCT_SEL_A_CTL;
      `DCT_TIMER_A_COMPARE: sel = DCT_SEL_A_CMP;
      `DCT_TIMER_A_COUNT:   sel = DCT_SEL_A_CNT;
      `DCT_TIMER_B_CONTROL: sel = DCT_SEL_B_CTL;
      `DCT_TIMER_B_COMPARE: sel = DCT_SEL_B_CMP;
      `DCT_TIMER_B_COUNT:   sel = DCT_SEL_B_CNT;
      `DCT_TICK_B_CONTROL:  sel = DCT_SEL_TICK;
      `DCT_IRQ_STATUS:      sel = DCT_SEL_STAT;
      `DCT_IRQ_CLEAR:       sel = DCT_SEL_CLR;
      `DCT_IRQ_ENABLE:      sel = DCT_SEL_IEN;
      default:              sel = DCT_SEL_NONE;
    endcase
  end

  wire we_a_ctl = reg_we && (sel == DCT_SEL_A_CTL);
  wire we_a_cmp = reg_we && (sel == DCT_SEL_A_CMP);
  wire we_a_cnt = reg_we && (sel == DCT_SEL_A_CNT);
  wire we_b_ctl = reg_we && (sel == DCT_SEL_B_CTL);
  wire we_b_cmp = reg_we && (sel == DCT_SEL_B_CMP);
  wire we_b_cnt = reg_we && (sel == DCT_SEL_B_CNT);
  wire we_tick  = reg_we && (sel == DCT_SEL_TICK);
  wire we_clr   = reg_we && (sel == DCT_SEL_CLR);
  wire we_ien   = reg_we && (sel == DCT_SEL_IEN);

  assign a_if.ctrl_we = we_a_ctl;
  assign a_if.cmp_we  = we_a_cmp;
  assign a_if.cnt_we  = we_a_cnt;   // RULE5
  assign a_if.wdata   = reg_wdata;
  assign b_if.ctrl_we = we_b_ctl;
  assign b_if.cmp_we  = we_b_cmp;
  assign b_if.cnt_we  = we_b_cnt;   // RULE6
  assign b_if.wdata   = reg_wdata;
  assign t_if.ctrl_we = we_tick;
  assign t_if.cmp_we  = 1'b0;
  assign t_if.cnt_we  = 1'b0;
  assign t_if.wdata   = reg_wdata;

  // Timer clock: one step pulse every TIMER_DIV cycles
  logic [15:0] pre_reg;
  wire         pre_wrap = (pre_reg == 16'(TIMER_DIV - 1));
  wire         step     = pre_wrap;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_wrap ? 16'h0000 : pre_reg + 16'h0001;
    end
  end

  dct_timer #(.W(32)) u_timer_a (
    .clock (clock),
    .rst_n (rst_n),
    .step  (step),
    .bus   (a_if)
  );

  dct_timer #(.W(32)) u_timer_b (
    .clock (clock),
    .rst_n (rst_n),
    .step  (step),
    .bus   (b_if)
  );

  dct_tick #(.PERIOD(TICK_CYCLES)) u_tick_b (
    .clock (clock),
    .rst_n (rst_n),
    .bus   (t_if)
  );

  // Sticky event status, write-only clear, enable mask
  dct_event_type status_reg, status_next;
  dct_event_type ien_reg;
  dct_event_type events;
  dct_event_type clr_bits;

  assign events[`DCT_EV_TIMER_A] = a_if.hit;
  assign events[`DCT_EV_TIMER_B] = b_if.hit;
  assign events[`DCT_EV_TICK_B]  = t_if.hit;
  assign clr_bits    = we_clr ? reg_wdata[2:0] : 3'h0;
  // Set wins over a clear in the same cycle
  assign status_next = events | (status_reg & ~clr_bits);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `DCT_EVENT_RESET;
      ien_reg    <= `DCT_EVENT_RESET;
    end else begin
      status_reg <= status_next;
      if (we_ien) begin
        ien_reg <= reg_wdata[2:0];
      end
    end
  end

  // Per-unit lines follow the pending flags
  assign timer_a_irq = a_if.irq;   // RULE1 RULE3
  assign timer_b_irq = b_if.irq;   // RULE2 RULE3
  assign tick_b_irq  = t_if.irq;
  assign irq         = |(status_reg & ien_reg);

  // Read data for the cycle after the strobe
  logic [31:0] rd_value;
  always_comb begin
    unique case (sel)
      DCT_SEL_A_CTL: rd_value = {29'h0, a_if.ctrl_q};
      DCT_SEL_A_CMP: rd_value = a_if.cmp_q;
      DCT_SEL_A_CNT: rd_value = a_if.cnt_q;   // RULE5
      DCT_SEL_B_CTL: rd_value = {29'h0, b_if.ctrl_q};
      DCT_SEL_B_CMP: rd_value = b_if.cmp_q;
      DCT_SEL_B_CNT: rd_value = b_if.cnt_q;   // RULE6
      DCT_SEL_TICK:  rd_value = {29'h0, t_if.ctrl_q};
      DCT_SEL_STAT:  rd_value = {29'h0, status_reg};
      DCT_SEL_IEN:   rd_value = {29'h0, ien_reg};
      default:       rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_re ? rd_value : 32'h0000_0000;
    end
  end

  // Match, clear and count terms as the units see them, for the checks below
  wire match_a = a_if.ctrl_q[`DCT_GATE_BIT] && (a_if.cnt_q == a_if.cmp_q);
  wire match_b = b_if.ctrl_q[`DCT_GATE_BIT] && (b_if.cnt_q == b_if.cmp_q);
  wire clear_a = we_a_ctl && reg_wdata[`DCT_FLAG_BIT];
  wire clear_b = we_b_ctl && reg_wdata[`DCT_FLAG_BIT];
  wire clear_t = we_tick && reg_wdata[`DCT_FLAG_BIT];
  wire run_a   = a_if.ctrl_q[`DCT_ENABLE_BIT] && step && !we_a_cnt;
  wire run_b   = b_if.ctrl_q[`DCT_ENABLE_BIT] && step && !we_b_cnt;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_timer_b_match: assert property (b_if.ctrl_q[`DCT_GATE_BIT] && b_if.cnt_q == b_if.cmp_q |=> timer_b_irq)  // RULE2
    else $error("timer B match did not raise its interrupt");
  a_timer_a_match: assert property (a_if.ctrl_q[`DCT_GATE_BIT] && a_if.cnt_q == a_if.cmp_q |=> timer_a_irq)  // RULE1
    else $error("timer A match did not raise its interrupt");
  a_read_count_a: assert property (reg_re && sel == DCT_SEL_A_CNT |=> reg_rdata == $past(a_if.cnt_q))  // RULE5
    else $error("timer A count read mismatch");
  a_read_count_b: assert property (reg_re && sel == DCT_SEL_B_CNT |=> reg_rdata == $past(b_if.cnt_q))  // RULE6
    else $error("timer B count read mismatch");
  a_load_count_b: assert property (we_b_cnt |=> b_if.cnt_q == $past(reg_wdata))  // RULE6
    else $error("timer B count write not loaded");
  a_b_irq_holds: assert property (timer_b_irq && !(we_b_ctl && reg_wdata[`DCT_FLAG_BIT]) |=> timer_b_irq)  // RULE3
    else $error("timer B interrupt dropped without a clear");
  a_b_flag_clear: assert property (we_b_ctl && reg_wdata[`DCT_FLAG_BIT] && !b_if.hit
                                   && !(b_if.ctrl_q[`DCT_GATE_BIT] && b_if.cnt_q == b_if.cmp_q)
                                   |=> !b_if.ctrl_q[`DCT_FLAG_BIT])  // RULE4
    else $error("timer B flag not cleared by writing one");
  a_tick_read_back: assert property (reg_re && sel == DCT_SEL_TICK |=> reg_rdata[31:2] == 30'h0)  // RULE7
    else $error("tick control reserved bits not zero");
  a_status_sticky: assert property (status_reg[`DCT_EV_TIMER_A] && !we_clr |=> status_reg[`DCT_EV_TIMER_A])
    else $error("status bit lost without a clear");
  a_irq_level: assert property (a_if.hit && ien_reg[`DCT_EV_TIMER_A] && !we_ien |=> irq)
    else $error("enabled timer A event did not raise the combined interrupt");
  a_rdata_one_cycle: assert property (!reg_re |=> reg_rdata == 32'h0000_0000)
    else $error("read data stood outside the answer cycle");

  // Timer A counterparts of the timer B checks, plus flag-keep and match-only checks for both timers
  a_load_count_a: assert property (we_a_cnt |=> a_if.cnt_q == $past(reg_wdata))  // RULE5
    else $error("timer A count write not loaded");

  a_a_irq_holds: assert property (timer_a_irq && !clear_a |=> timer_a_irq)  // RULE3
    else $error("timer A interrupt dropped without a clear");

  a_a_flag_clear: assert property (clear_a && !match_a |=> !a_if.ctrl_q[`DCT_FLAG_BIT])  // RULE4
    else $error("timer A flag not cleared by writing one");

  a_a_flag_keeps: assert property (we_a_ctl && !reg_wdata[`DCT_FLAG_BIT] && timer_a_irq |=> timer_a_irq)  // RULE4
    else $error("timer A flag changed by writing zero");

  a_b_flag_keeps: assert property (we_b_ctl && !reg_wdata[`DCT_FLAG_BIT] && timer_b_irq |=> timer_b_irq)  // RULE4
    else $error("timer B flag changed by writing zero");

  a_a_only_match: assert property (!match_a && !timer_a_irq |=> !timer_a_irq)  // RULE1
    else $error("timer A flag set without a gated match");

  a_b_only_match: assert property (!match_b && !timer_b_irq |=> !timer_b_irq)  // RULE2
    else $error("timer B flag set without a gated match");

  // Counting and register writes
  a_a_count_step: assert property (run_a |=> a_if.cnt_q == $past(a_if.cnt_q) + 32'h1)  // RULE9
    else $error("timer A count did not advance by one");

  a_b_count_step: assert property (run_b |=> b_if.cnt_q == $past(b_if.cnt_q) + 32'h1)  // RULE9
    else $error("timer B count did not advance by one");

  a_a_count_hold: assert property (!a_if.ctrl_q[`DCT_ENABLE_BIT] && !we_a_cnt |=> $stable(a_if.cnt_q))  // RULE9
    else $error("disabled timer A count moved");

  a_b_count_hold: assert property (!b_if.ctrl_q[`DCT_ENABLE_BIT] && !we_b_cnt |=> $stable(b_if.cnt_q))  // RULE9
    else $error("disabled timer B count moved");

  a_a_enable_write: assert property (we_a_ctl |=> a_if.ctrl_q[`DCT_ENABLE_BIT] == $past(reg_wdata[`DCT_ENABLE_BIT]))
    else $error("timer A enable bit not written");

  a_a_gate_write: assert property (we_a_ctl |=> a_if.ctrl_q[`DCT_GATE_BIT] == $past(reg_wdata[`DCT_GATE_BIT]))
    else $error("timer A gate bit not written");

  a_b_enable_write: assert property (we_b_ctl |=> b_if.ctrl_q[`DCT_ENABLE_BIT] == $past(reg_wdata[`DCT_ENABLE_BIT]))
    else $error("timer B enable bit not written");

  a_b_gate_write: assert property (we_b_ctl |=> b_if.ctrl_q[`DCT_GATE_BIT] == $past(reg_wdata[`DCT_GATE_BIT]))
    else $error("timer B gate bit not written");

  a_a_cmp_write: assert property (we_a_cmp |=> a_if.cmp_q == $past(reg_wdata))
    else $error("timer A compare write not loaded");

  a_b_cmp_write: assert property (we_b_cmp |=> b_if.cmp_q == $past(reg_wdata))
    else $error("timer B compare write not loaded");

  a_a_cmp_holds: assert property (!we_a_cmp |=> $stable(a_if.cmp_q))
    else $error("timer A compare changed without a write");

  a_b_cmp_holds: assert property (!we_b_cmp |=> $stable(b_if.cmp_q))
    else $error("timer B compare changed without a write");

  // Tick unit
  a_tick_holds: assert property (tick_b_irq && !clear_t |=> tick_b_irq)  // RULE7
    else $error("tick interrupt dropped without a clear");

  a_tick_gate_write: assert property (we_tick |=> t_if.ctrl_q[`DCT_GATE_BIT] == $past(reg_wdata[`DCT_GATE_BIT]))  // RULE7
    else $error("tick gate bit not written");

  a_tick_no_gate: assert property (!t_if.ctrl_q[`DCT_GATE_BIT] && !tick_b_irq |=> !tick_b_irq)  // RULE7
    else $error("tick flag set with the gate closed");

  // Sticky status and enable
  a_status_a_set: assert property (a_if.hit |=> status_reg[`DCT_EV_TIMER_A])
    else $error("timer A event not recorded");

  a_status_b_set: assert property (b_if.hit |=> status_reg[`DCT_EV_TIMER_B])
    else $error("timer B event not recorded");

  a_status_t_set: assert property (t_if.hit |=> status_reg[`DCT_EV_TICK_B])
    else $error("tick event not recorded");

  a_status_a_clear: assert property (we_clr && reg_wdata[`DCT_EV_TIMER_A] && !a_if.hit |=> !status_reg[`DCT_EV_TIMER_A])
    else $error("timer A status not cleared");

  a_status_b_clear: assert property (we_clr && reg_wdata[`DCT_EV_TIMER_B] && !b_if.hit |=> !status_reg[`DCT_EV_TIMER_B])
    else $error("timer B status not cleared");

  a_status_t_clear: assert property (we_clr && reg_wdata[`DCT_EV_TICK_B] && !t_if.hit |=> !status_reg[`DCT_EV_TICK_B])
    else $error("tick status not cleared");

  a_status_a_quiet: assert property (!a_if.hit && !status_reg[`DCT_EV_TIMER_A] |=> !status_reg[`DCT_EV_TIMER_A])
    else $error("timer A status set without an event");

  a_ien_write: assert property (we_ien |=> ien_reg == $past(reg_wdata[2:0]))
    else $error("enable register not written");

  // Read data
  a_read_cmp_a: assert property (reg_re && sel == DCT_SEL_A_CMP |=> reg_rdata == $past(a_if.cmp_q))
    else $error("timer A compare read mismatch");

  a_read_cmp_b: assert property (reg_re && sel == DCT_SEL_B_CMP |=> reg_rdata == $past(b_if.cmp_q))
    else $error("timer B compare read mismatch");

  a_read_ctl_a: assert property (reg_re && sel == DCT_SEL_A_CTL |=> reg_rdata == {29'h0, $past(a_if.ctrl_q)})
    else $error("timer A control read mismatch");

  a_read_ctl_b: assert property (reg_re && sel == DCT_SEL_B_CTL |=> reg_rdata == {29'h0, $past(b_if.ctrl_q)})
    else $error("timer B control read mismatch");

  a_read_status: assert property (reg_re && sel == DCT_SEL_STAT |=> reg_rdata == {29'h0, $past(status_reg)})
    else $error("status read mismatch");

  a_read_ien: assert property (reg_re && sel == DCT_SEL_IEN |=> reg_rdata == {29'h0, $past(ien_reg)})
    else $error("enable register read mismatch");

  a_read_unmapped: assert property (reg_re && (sel == DCT_SEL_NONE || sel == DCT_SEL_CLR) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped or clear register read not zero");
endmodule // dct_top

// >>> dct_map.svh
/*
  Register offsets, field positions, reset values and timing figures
  of the dual compare timer. Assumes byte addresses on a 32-bit port.
*/
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

`define DCT_ADDR_W            8
`define DCT_TIMER_A_CONTROL   8'h08
`define DCT_TIMER_A_COMPARE   8'h0c
`define DCT_TIMER_A_COUNT     8'h10
`define DCT_TIMER_B_CONTROL   8'h14
`define DCT_TIMER_B_COMPARE   8'h18
`define DCT_TIMER_B_COUNT     8'h1c
`define DCT_TICK_B_CONTROL    8'h20
`define DCT_IRQ_STATUS        8'h24
`define DCT_IRQ_CLEAR         8'h28
`define DCT_IRQ_ENABLE        8'h2c

`define DCT_FLAG_BIT          0
`define DCT_GATE_BIT          1
`define DCT_ENABLE_BIT        2

`define DCT_CONTROL_RESET     3'h0
`define DCT_VALUE_RESET       32'h0000_0000
`define DCT_EVENT_RESET       3'h0

`define DCT_EV_TIMER_A        0
`define DCT_EV_TIMER_B        1
`define DCT_EV_TICK_B         2

`define DCT_CLOCK_KHZ         250000
`define DCT_TICK_PERIOD_MS    500
`define DCT_TIMER_DIV         1

`endif

// >>> dct_pkg.sv
/*
  Types shared by the dual compare timer modules.
  Assumes nothing beyond the constant header.
*/
package dct_pkg;
  typedef enum logic [3:0] {
    DCT_SEL_NONE, DCT_SEL_A_CTL, DCT_SEL_A_CMP, DCT_SEL_A_CNT,
    DCT_SEL_B_CTL, DCT_SEL_B_CMP, DCT_SEL_B_CNT, DCT_SEL_TICK,
    DCT_SEL_STAT, DCT_SEL_CLR, DCT_SEL_IEN
  } dct_sel_type;
  typedef logic [2:0] dct_event_type;
endpackage

// >>> dct_unit_if.sv
/*
  Link between the register front end and one timer or tick unit.
  Assumes the front end drives strobes for one cycle per write.
*/
`timescale 1ns/1ns
interface dct_unit_if #(parameter int W = 32);
  logic         ctrl_we;  // Control write strobe
  logic         cmp_we;   // Compare write strobe
  logic         cnt_we;   // Count write strobe
  logic [W-1:0] wdata;    // Write data
  logic [2:0]   ctrl_q;   // Control bits read back
  logic [W-1:0] cmp_q;    // Compare value
  logic [W-1:0] cnt_q;    // Current count
  logic         hit;      // One-cycle event pulse
  logic         irq;      // Level interrupt
  modport front (output ctrl_we, cmp_we, cnt_we, wdata, input ctrl_q, cmp_q, cnt_q, hit, irq);
  modport timer (input ctrl_we, cmp_we, cnt_we, wdata, output ctrl_q, cmp_q, cnt_q, hit, irq);
  modport tick  (input ctrl_we, wdata, output ctrl_q, hit, irq);
endinterface

// >>> dct_timer.sv
/*
  One 32-bit compare timer: control, compare and count registers.
  Assumes step is a one-cycle pulse per timer clock.
*/
`timescale 1ns/1ns
`include "dct_map.svh"
module dct_timer
  import dct_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic clock,   // Block clock
  input wire logic rst_n,   // Asynchronous reset, low
  input wire logic step,    // Timer clock enable
  dct_unit_if.timer bus     // Register side
);
  logic         en_reg, gate_reg, flag_reg;
  logic [W-1:0] cmp_reg, cnt_reg, cnt_next;
  wire          match = gate_reg && (cnt_reg == cmp_reg);
  wire          clr   = bus.ctrl_we && bus.wdata[`DCT_FLAG_BIT];
  wire          flag_next = match || (flag_reg && !clr);

  always_comb begin
    cnt_next = cnt_reg;
    if (bus.cnt_we) begin
      cnt_next = bus.wdata;
    end else if (en_reg && step) begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {en_reg, gate_reg, flag_reg} <= `DCT_CONTROL_RESET;
      cmp_reg <= W'(`DCT_VALUE_RESET);
      cnt_reg <= W'(`DCT_VALUE_RESET);
    end else begin
      if (bus.ctrl_we) begin
        en_reg   <= bus.wdata[`DCT_ENABLE_BIT];
        gate_reg <= bus.wdata[`DCT_GATE_BIT];
      end
      if (bus.cmp_we) begin
        cmp_reg <= bus.wdata;
      end
      flag_reg <= flag_next;   // RULE1 RULE2 RULE3 RULE4
      cnt_reg  <= cnt_next;    // RULE5 RULE6 RULE9
    end
  end

  assign bus.ctrl_q = {en_reg, gate_reg, flag_reg};
  assign bus.cmp_q  = cmp_reg;
  assign bus.cnt_q  = cnt_reg;
  assign bus.hit    = match && !flag_reg;
  assign bus.irq    = flag_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_match_sets_flag: assert property (match |=> bus.irq && flag_reg)  // RULE1
    else $error("match did not raise the interrupt");
  a_irq_until_clear: assert property (bus.irq && !clr |=> bus.irq)  // RULE3
    else $error("interrupt dropped without a clear");
  a_flag_one_clears: assert property (clr && !match |=> !flag_reg)  // RULE4
    else $error("writing one did not clear the flag");
  a_flag_zero_keeps: assert property (bus.ctrl_we && !bus.wdata[`DCT_FLAG_BIT] && flag_reg |=> flag_reg)  // RULE4
    else $error("writing zero changed the flag");
  a_count_load: assert property (bus.cnt_we |=> cnt_reg == $past(bus.wdata))  // RULE5
    else $error("count write not loaded");
  a_count_steps: assert property (en_reg && step && !bus.cnt_we |=> cnt_reg == $past(cnt_reg) + W'(1))  // RULE9
    else $error("enabled count did not advance by one");
  a_count_holds: assert property (!en_reg && !bus.cnt_we |=> $stable(cnt_reg))  // RULE9
    else $error("disabled count moved");
endmodule // dct_timer

// >>> dct_tick.sv
/*
  Half-second tick unit with interrupt gate and pending flag.
  Assumes PERIOD is the tick interval in clock cycles.
*/
`timescale 1ns/1ns
`include "dct_map.svh"
module dct_tick
  import dct_pkg::*;
#(
  parameter int PERIOD = `DCT_TICK_PERIOD_MS * `DCT_CLOCK_KHZ
) (
  input wire logic clock,   // Block clock
  input wire logic rst_n,   // Asynchronous reset, low
  dct_unit_if.tick bus      // Register side
);
  logic [31:0] div_reg;
  logic        gate_reg, flag_reg;
  wire         wrap  = (div_reg == 32'(PERIOD - 1));
  wire         event_now = wrap && gate_reg;
  wire         clr   = bus.ctrl_we && bus.wdata[`DCT_FLAG_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 32'h0000_0000;
      gate_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      div_reg  <= wrap ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      if (bus.ctrl_we) begin
        gate_reg <= bus.wdata[`DCT_GATE_BIT];
      end
      flag_reg <= event_now || (flag_reg && !clr);   // RULE7
    end
  end

  assign bus.ctrl_q = {1'b0, gate_reg, flag_reg};
  assign bus.hit    = event_now && !flag_reg;
  assign bus.irq    = flag_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_tick_clear: assert property (clr && !event_now |=> !flag_reg)  // RULE7
    else $error("tick flag not cleared by writing one");
  a_tick_sets: assert property (event_now |=> flag_reg)  // RULE7
    else $error("tick event did not set the flag");
endmodule // dct_tick

// >>> dct_top_tb.sv
/*
  Self-checking bench for the dual compare timer: register access, counting,
  compare interrupts, sticky status and the tick unit.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
`include "dct_map.svh"
module dct_top_tb;
  localparam int TICKS = 16;
  localparam int LIMIT = 5000;

  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_we    = 1'b0;
  logic        reg_re    = 1'b0;
  logic [31:0] reg_rdata;
  logic        timer_a_irq;
  logic        timer_b_irq;
  logic        tick_b_irq;
  logic        irq;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          i;
  int          n;
  logic [31:0] mdl [int];  // Bench copy of every value written
  logic [31:0] seed_val;
  logic [31:0] c;
  logic [31:0] v;
  logic [7:0]  b;

  dct_top #(.TICK_CYCLES(TICKS), .TIMER_DIV(1)) dct_top_i (
    .clock       (clock),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_we      (reg_we),
    .reg_re      (reg_re),
    .reg_rdata   (reg_rdata),
    .timer_a_irq (timer_a_irq),
    .timer_b_irq (timer_b_irq),
    .tick_b_irq  (tick_b_irq),
    .irq         (irq)
  );

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
    mdl[a] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic logic irq_of(input int k);
    return (k == 0) ? timer_a_irq : ((k == 1) ? timer_b_irq : tick_b_irq);
  endfunction

  // Waits a bounded time for an interrupt line to rise
  task automatic wait_irq(input int k);
    int w;
    w = 0;
    #1;
    while (irq_of(k) !== 1'b1 && w < 40) begin
      @(posedge clock);
      #1;
      w++;
    end
    chk({31'h0, irq_of(k)}, 32'h1);
  endtask

  initial begin
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("timeout at %0t", $time);
      end_sim();
    end
  end

  initial begin
    seed_val = $urandom(32'h4bcba45d);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, an unmapped place and the enable register
    for (i = 4; i <= 36; i += 4) begin
      rd(i[7:0], 32'h0);
    end
    rd(8'h2c, 32'h0);
    wr(8'h30, $urandom());
    rd(8'h30, 32'h0);
    $display("reset and map test done");
    for (i = 0; i < 2; i++) begin
      b = 8'h08 + 8'(i * 12);
      v = $urandom();
      wr(b, 32'h0);
      wr(b + 8'h8, v);
      rd(b + 8'h8, v);
      repeat (3) @(posedge clock);
      rd(b + 8'h8, mdl[b + 8'h8]);
      n = $urandom_range(12, 3);
      wr(b, 32'h4);
      repeat (n) @(posedge clock);
      wr(b, 32'h0);
      rd(b + 8'h8, v + 32'(n + 2));
      c = $urandom();
      wr(b + 8'h4, c);
      wr(b + 8'h8, c - 32'h5);
      rd(b + 8'h4, mdl[b + 8'h4]);
      wr(b, 32'h6);
      wait_irq(i);
      repeat (4) @(posedge clock);
      #1 chk({31'h0, irq_of(i)}, 32'h1);
      wr(b, 32'h2);
      rd(b, 32'h3);
      wr(b, 32'h3);
      #1 chk({31'h0, irq_of(i)}, 32'h0);
      rd(b, 32'h2);
      // Count runs through the compare value with the gate closed
      wr(b + 8'h8, c - 32'h3);
      wr(b, 32'h4);
      repeat (10) begin
        @(posedge clock);
        #1 chk({31'h0, irq_of(i)}, 32'h0);
      end
      wr(b, 32'h0);
      $display("timer %0d test done", i);
    end
    // Sticky status, enable and clear of the combined line
    rd(8'h24, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(8'h2c, 32'h3);
    #1 chk({31'h0, irq}, 32'h1);
    rd(8'h2c, 32'h3);
    wr(8'h28, 32'h1);
    rd(8'h24, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(8'h28, 32'h2);
    #1 chk({31'h0, irq}, 32'h0);
    rd(8'h24, 32'h0);
    $display("combined interrupt test done");
    // Tick unit: bit 2 is not stored, flag clears on a one
    wr(8'h20, 32'h6);
    wait_irq(2);
    rd(8'h20, 32'h3);
    wr(8'h20, 32'h3);
    #1 chk({31'h0, tick_b_irq}, 32'h0);
    rd(8'h20, 32'h2);
    wr(8'h20, 32'h0);
    rd(8'h24, 32'h4);
    chk({31'h0, irq}, 32'h0);
    $display("tick test done");
    // Reset in mid-run with timer A counting: everything returns to zero
    wr(8'h08, 32'h4);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h2c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule // dct_top_tb
